/* ms_tick_gen.v */
// Purpose: free-running one-cycle millisecond tick
// Assumes: single system clock
// Notes: tick is a one-cycle enable, not a clock
`timescale 1ns/1ps
`default_nettype none
`include "status_led_regs.vh"
module ms_tick_gen #(
  parameter CYCLES = `MS_CYCLES
) (
  // clock and reset
  input wire clk_sys_i,
  input wire arst_n_i,
  // tick
  output reg tick_o
);
  reg [31:0] cnt_q;

  always @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cnt_q <= 32'h0;
      tick_o <= 1'b0;
    end
    else if (cnt_q == CYCLES - 1)
    begin
      cnt_q <= 32'h0;
      tick_o <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 32'h1;
      tick_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* status_lamp.sv */
// Purpose: two-colour lamp on the far side of the indicator drives
// Assumes: a colour lights while its drive is high
// Notes: code 0 dark, 1 green, 2 yellow, 3 both
`timescale 1ns/1ps
`default_nettype none
module status_lamp (
  // drives
  input wire logic yel_i,
  input wire logic grn_i,
  // colour seen
  output logic [1:0] color_o
);
  assign color_o = {yel_i, grn_i};
endmodule
`default_nettype wire

/* status_led_asserts.sv */
// Purpose: checker on the indicator drives
// Assumes: parameters handed on from the design
// Notes: run_q counts cycles a lamp code stands, restarted on a condition change
`timescale 1ns/1ps
`default_nettype none
module status_led_asserts #(
  parameter MS_CYCLES = 2,
  parameter SLOW_MS = 4,
  parameter FAST_MS = 2
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // conditions
  input wire logic fw_reset_i,
  input wire logic fw_running_i,
  input wire logic fs_format_i,
  input wire logic sys_error_i,
  input wire logic fw_crash_i,
  input wire logic upd_idle_i,
  input wire logic upd_install_i,
  input wire logic net_cyclic_i,
  input wire logic net_flash_i,
  // drives
  input wire logic system_status_indicator_yellow_o,
  input wire logic system_status_indicator_green_o,
  input wire logic network_status_indicator_green_o
);
  wire hi = fw_reset_i | fw_crash_i | sys_error_i;
  wire upd = upd_idle_i | upd_install_i;
  wire y = system_status_indicator_yellow_o;
  wire g = system_status_indicator_green_o;
  wire [6:0] sys_in = {fw_reset_i, fw_crash_i, sys_error_i, upd_install_i, upd_idle_i,
    fs_format_i, fw_running_i};
  logic [6:0] in_q;
  logic chg_q;
  logic chg2_q;
  logic [1:0] lit_q;
  int run_q;
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      lit_q <= 2'h0;
      run_q <= 0;
      in_q <= 7'h00;
      chg_q <= 1'b0;
      chg2_q <= 1'b0;
    end
    else
    begin
      lit_q <= {y, g};
      in_q <= sys_in;
      chg_q <= (sys_in != in_q);
      chg2_q <= chg_q;
      // a restart may reuse the old colour, so the count starts over with the new pattern
      run_q <= ({y, g} == lit_q && !chg2_q) ? run_q + 1 : 0;
    end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  sequence run_s; fw_running_i && !hi && !upd && !fs_format_i; endsequence
  sequence err_s; sys_error_i && !fw_reset_i && !fw_crash_i; endsequence
  sequence crash_s; fw_crash_i && !fw_reset_i; endsequence
  sequence inst_s; upd_install_i && !hi; endsequence
  sequence slow_s; (upd_idle_i || fs_format_i) && !hi && !upd_install_i; endsequence
  chk_one_colour: assert property (!(y && g))
    else $error("both colours lit");
  chk_run_green: assert property (run_s [*3] |-> g && !y)
    else $error("running lamp not green");
  chk_error_yellow: assert property (err_s [*3] |-> y && !g)
    else $error("error lamp not yellow");
  chk_reset_dark: assert property (fw_reset_i [*3] |-> !y && !g)
    else $error("lamp lit in reset");
  chk_net_steady: assert property (net_cyclic_i |=> network_status_indicator_green_o)
    else $error("network lamp not green");
  chk_crash_opens: assert property (!fw_crash_i ##1 crash_s [*3] |-> y)
    else $error("crash pattern not opening yellow");
  chk_fast_phase: assert property (inst_s [*5] |-> run_q < FAST_MS * MS_CYCLES)
    else $error("install phase too long");
  chk_slow_phase: assert property (slow_s [*5] |-> run_q < SLOW_MS * MS_CYCLES)
    else $error("slow phase too long");
endmodule
bind status_led_pattern_gen status_led_asserts #(.MS_CYCLES(MS_CYCLES), .SLOW_MS(SLOW_MS),
  .FAST_MS(FAST_MS)) u_chk (.*);
`default_nettype wire

/* status_led_pattern_gen.v */
// Purpose: drive the two-colour system status indicator and the green
//          half of the network status indicator
// Assumes: condition inputs come from logic on clk_sys_i
// Notes: yellow and green never lit together
`timescale 1ns/1ps
`default_nettype none
`include "status_led_regs.vh"
module status_led_pattern_gen #(
  parameter MS_CYCLES = `MS_CYCLES,
  parameter SLOW_MS = `SLOW_PHASE_MS,
  parameter FAST_MS = `FAST_PHASE_MS
) (
  // clock and reset
  input wire clk_sys_i,
  input wire arst_n_i,
  // firmware and device condition
  input wire fw_reset_i,
  input wire fw_running_i,
  input wire fs_format_i,
  input wire sys_error_i,
  input wire fw_crash_i,
  input wire upd_idle_i,
  input wire upd_install_i,
  // network condition
  input wire net_cyclic_i,
  input wire net_flash_i,
  // indicator drives
  output reg system_status_indicator_yellow_o,
  output reg system_status_indicator_green_o,
  output reg network_status_indicator_green_o
);
  // ------------------------------------------------------------
  // millisecond tick
  // ------------------------------------------------------------
  wire tick;

  ms_tick_gen #(
    .CYCLES(MS_CYCLES)
  ) u_tick (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .tick_o(tick)
  );

  // ------------------------------------------------------------
  // condition select
  // ------------------------------------------------------------
  reg [2:0] cond_d;

  // fw_reset_i beats crash: a lamp lit during reset would look like live firmware
  always @*
  begin
    if (fw_reset_i)
      cond_d = `COND_OFF;
    else if (fw_crash_i)
      cond_d = `COND_CRASH;
    else if (sys_error_i)
      cond_d = `COND_ERROR;
    else if (upd_install_i)
      cond_d = `COND_UPD_INST;
    else if (upd_idle_i)
      cond_d = `COND_UPD_IDLE;
    else if (fs_format_i)
      cond_d = `COND_FORMAT;
    else if (fw_running_i)
      cond_d = `COND_RUN;
    else
      cond_d = `COND_OFF;
  end

  // ------------------------------------------------------------
  // phase timing
  // ------------------------------------------------------------
  reg [2:0] cond_q;
  reg [9:0] ms_q;
  reg [2:0] step_q;
  reg [9:0] net_ms_q;
  reg net_on_q;
  wire [9:0] phase_len;
  wire [2:0] step_last;
  wire phase_end;

  // installing uses the short phase, every other pattern the long one
  assign phase_len = (cond_q == `COND_UPD_INST) ? FAST_MS[9:0] : SLOW_MS[9:0];
  // crash steps below the pulse count are yellow, the rest green; each has an on and an off half
  localparam [2:0] PULSES = `CRASH_PULSES;
  localparam [2:0] CRASH_LAST = PULSES + PULSES - 3'h1;

  // crash walks 2*3 pulses of on/off = 12 phases; the rest toggle two phases
  assign step_last = (cond_q == `COND_CRASH) ? CRASH_LAST : 3'h1;
  assign phase_end = tick && (ms_q == phase_len - 10'h1);

  reg half_q;

  always @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cond_q <= `COND_OFF;
      ms_q <= 10'h0;
      step_q <= 3'h0;
      half_q <= 1'b0;
    end
    else if (cond_d != cond_q)
    begin
      // restart from first phase so a new state is visible at once
      cond_q <= cond_d;
      ms_q <= 10'h0;
      step_q <= 3'h0;
      half_q <= 1'b0;
    end
    else if (phase_end)
    begin
      ms_q <= 10'h0;
      if (cond_q == `COND_CRASH)
      begin
        half_q <= ~half_q;
        if (half_q)
          step_q <= (step_q == step_last) ? 3'h0 : step_q + 3'h1;
      end
      else
        step_q <= (step_q == step_last) ? 3'h0 : step_q + 3'h1;
    end
    else if (tick)
      ms_q <= ms_q + 10'h1;
  end

  // ------------------------------------------------------------
  // network flash timing
  // ------------------------------------------------------------
  // net_on_q idles high so a new flash request opens with the lit half
  always @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      net_ms_q <= 10'h0;
      net_on_q <= 1'b1;
    end
    else if (!net_flash_i)
    begin
      net_ms_q <= 10'h0;
      net_on_q <= 1'b1;
    end
    else if (tick)
    begin
      if (net_ms_q == SLOW_MS[9:0] - 10'h1)
      begin
        net_ms_q <= 10'h0;
        net_on_q <= ~net_on_q;
      end
      else
        net_ms_q <= net_ms_q + 10'h1;
    end
  end

  // ------------------------------------------------------------
  // lamp drive
  // ------------------------------------------------------------
  reg yel_d;
  reg grn_d;

  always @*
  begin
    yel_d = 1'b0;
    grn_d = 1'b0;
    case (cond_q)
      `COND_RUN:
        grn_d = 1'b1;
      `COND_FORMAT:
        grn_d = ~step_q[0];
      `COND_ERROR:
        yel_d = 1'b1;
      `COND_CRASH:
      begin
        yel_d = ~half_q && (step_q < PULSES);
        grn_d = ~half_q && (step_q >= PULSES);
      end
      `COND_UPD_IDLE,
      `COND_UPD_INST:
      begin
        yel_d = ~step_q[0];
        grn_d = step_q[0];
      end
      default:
      begin
        yel_d = 1'b0;
        grn_d = 1'b0;
      end
    endcase
  end

  // registered drives keep the lamp pins glitch-free while cond_q moves
  always @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      system_status_indicator_yellow_o <= 1'b0;
      system_status_indicator_green_o <= 1'b0;
      network_status_indicator_green_o <= 1'b0;
    end
    else
    begin
      system_status_indicator_yellow_o <= yel_d;
      system_status_indicator_green_o <= grn_d;
      network_status_indicator_green_o <= net_cyclic_i | (net_flash_i & net_on_q);
    end
  end
endmodule
`default_nettype wire

/* status_led_pattern_gen_test.sv */
// Purpose: self-checking bench for the indicator block
// Assumes: 2-cycle tick, slow phase 4 ticks, fast phase 2 ticks
// Notes: expected lamp codes packed two bits each, oldest first
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin mismatches++; \
  $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module status_led_pattern_gen_test;
  localparam [8:0] R = 9'h100, C = 9'h080, E = 9'h040, I = 9'h020, D = 9'h010;
  localparam [8:0] F = 9'h008, U = 9'h004, N = 9'h002, L = 9'h001;
  logic clk_sys_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [8:0] cond = 9'h000;
  logic [1:0] color;
  logic y, g, net_g;
  int mismatches = 0;
  int n_checks = 0;
  initial forever #10 clk_sys_i = ~clk_sys_i;
  status_led_pattern_gen #(.MS_CYCLES(2), .SLOW_MS(4), .FAST_MS(2)) dut (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .fw_reset_i(cond[8]), .fw_crash_i(cond[7]),
    .sys_error_i(cond[6]), .upd_install_i(cond[5]), .upd_idle_i(cond[4]),
    .fs_format_i(cond[3]), .fw_running_i(cond[2]), .net_cyclic_i(cond[1]),
    .net_flash_i(cond[0]), .system_status_indicator_yellow_o(y),
    .system_status_indicator_green_o(g), .network_status_indicator_green_o(net_g));
  status_lamp lamp (.yel_i(y), .grn_i(g), .color_o(color));
  task wt(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task go(input [8:0] v);
    @(posedge clk_sys_i);
    cond <= v;
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // walks n phases from dark, the second one timed
  task watch(input [8:0] v, input int n, input [23:0] e, input int len);
    logic [1:0] c;
    int k;
    go(9'h000);
    wt(3);
    go(v);
    wt(2);
    for (int i = 0; i < n; i++)
    begin
      c = color;
      k = 0;
      while (color === c && k < 100)
      begin
        wt(1);
        k++;
      end
      `CHK("lamp", e[2*(n-1-i) +: 2], c)
      if (i == 1) `CHK("phase", len, k)
    end
  endtask
  task t_dark;
    go(R | C | E | U);
    wt(3);
    `CHK("reset lamp", 2'h0, color)
  endtask
  task t_run;
    go(U | N);
    wt(3);
    `CHK("run lamp", 2'h1, color)
    `CHK("net lamp", 1'b1, net_g)
    go(U | F | D | I | E);
    wt(3);
    `CHK("error lamp", 2'h2, color)
    go(9'h000);
    wt(3);
    go(L);
    wt(2);
    `CHK("net flash", 1'b1, net_g)
    wt(10);
    `CHK("net flash off", 1'b0, net_g)
    wt(8);
    `CHK("net flash on", 1'b1, net_g)
  endtask
  task t_update;
    watch(D, 4, 24'h99, 8);
    watch(I | D | F, 4, 24'h99, 4);
  endtask
  task t_restart;
    go(9'h000);
    wt(3);
    go(D);
    wt(13);
    `CHK("idle green", 2'h1, color)
    go(I);
    wt(2);
    `CHK("restart", 2'h2, color)
  endtask
  initial
  begin
    wt(12);
    `CHK("dark in reset", 2'h0, color)
    arst_n_i <= 1'b1;
    t_dark;
    t_run;
    watch(C, 12, 24'h888444, 8);
    watch(F | U, 3, 24'h11, 8);
    t_update;
    t_restart;
    complete_run;
  end
  initial
  begin
    repeat (3000) @(posedge clk_sys_i);
    mismatches++;
    complete_run;
  end
endmodule
`default_nettype wire

/* status_led_regs.vh */
// Purpose: timing and code constants for the status indicator block
// Assumes: 50 MHz system clock
// Notes: definitions only
`ifndef STATUS_LED_REGS_VH
`define STATUS_LED_REGS_VH
// --------------------------------------------------------------
// timing
// --------------------------------------------------------------
`define CLK_HZ 50000000
`define TICK_MS 1
`define MS_CYCLES ((`CLK_HZ / 1000) * `TICK_MS)
`define SLOW_PHASE_MS 500
`define FAST_PHASE_MS 125
`define CRASH_PULSES 3'h3
// --------------------------------------------------------------
// condition codes
// --------------------------------------------------------------
`define COND_OFF 3'h0
`define COND_RUN 3'h1
`define COND_FORMAT 3'h2
`define COND_UPD_IDLE 3'h3
`define COND_UPD_INST 3'h4
`define COND_ERROR 3'h5
`define COND_CRASH 3'h6
`endif
